// >>> hdl/epd_cmd_decoder.sv
// Serial command decoder of the panel driver: framing, opcode decode, parameter store, reads
// How it works
// - Byte with select low is an opcode; with select high it is a parameter.
// - Mode select low uses 8-bit frames with select pin; high uses 9-bit frames.
// - Opcode 00h stores one panel setting byte, default 07h.
// - Opcode 01h stores five power bytes; source levels default 26h, 26h, 03h.
// - Opcode 02h is power-off, no parameters.
// - Opcode 03h stores one power-off timing byte, default 00h.
// - Opcode 04h is power-on, no parameters.
// - Opcode 21h starts loading the white-to-white table.
// - Opcode 22h starts loading the black-to-white table.
// - Opcode 23h starts loading the white-to-black table.
// - Opcode 24h starts loading the black-to-black table.
// - Opcode 40h returns temperature bits 10..3, then bits 2..0 at the top.
// - Opcode 50h stores one border/interval byte, default D7h.
// - Opcode 71h returns one status byte; reset sets its power-off bit and clears its power-on bit.
// - Don't-care parameter bits are dropped and read as zero.
module epd_cmd_decoder (
   // Clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // Serial port, all sampled on core_clk
   input wire logic spi_cs_n,
   input wire logic spi_sclk,
   input wire logic cmd_param_select,
   input wire logic serial_mode_select,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   // Driver state from the panel engine
   input wire logic engine_busy,
   input wire logic i2c_err,
   input wire logic i2c_busy_n,
   input wire logic data_flag,
   input wire logic [10:0] temp_value,
   output logic busy_n,
   // Stored parameters
   output logic [7:0] panel_setting,
   output logic [7:0] pwr_enables,
   output logic [7:0] pwr_levels,
   output logic [7:0] source_high_level,
   output logic [7:0] source_low_level,
   output logic [7:0] red_source_level,
   output logic [7:0] power_off_sequence,
   output logic [7:0] pll_control,
   output logic [7:0] vcom_data_interval,
   output logic [7:0] timing_control_setting,
   output logic [7:0] vcom_value,
   output logic [7:0] vcom_dc_setting,
   // Command events
   output logic power_down_pulse,
   output logic power_up_pulse,
   output logic table_start_pulse,
   output logic [1:0] table_select,
   output logic table_data_valid,
   output logic [7:0] table_data
);
   import epd_cmd_pkg::*;

   epd_state_e state_ff;
   epd_state_e nxt_state;
   logic sclk_ff;
   logic [3:0] bit_cnt_ff;
   logic dc_bit_ff;
   logic [7:0] rx_ff;
   logic [7:0] tx_ff;
   logic [7:0] opcode_ff;
   logic [2:0] pidx_ff;
   logic [1:0] ridx_ff;
   logic pon_ff;
   logic pof_ff;

   // Framing
   wire sclk_rise = spi_sclk & ~sclk_ff & ~spi_cs_n;
   wire mode3 = serial_mode_select;
   wire [3:0] frame_len = mode3 ? FRAME_3WIRE : FRAME_4WIRE;
   wire dc_slot = mode3 && (bit_cnt_ff == 4'd0);
   wire last_bit = (bit_cnt_ff == frame_len - 4'd1);
   wire byte_done = sclk_rise && last_bit;
   wire [7:0] rx_byte = {rx_ff[6:0], sda_in};
   wire dc_level = mode3 ? dc_bit_ff : cmd_param_select;
   wire got_cmd = byte_done && !dc_level;
   wire got_param = byte_done && dc_level;

   // Opcode decode of the byte just received
   wire is_panel = rx_byte == OP_PANEL_CONFIG;
   wire is_pwr = rx_byte == OP_POWER_LEVELS;
   wire is_pdown = rx_byte == OP_POWER_DOWN;
   wire is_pfs = rx_byte == OP_POWER_DOWN_TIMING;
   wire is_pup = rx_byte == OP_POWER_UP;
   wire is_ww = rx_byte == OP_WHITE_WHITE;
   wire is_bw = rx_byte == OP_BLACK_WHITE;
   wire is_wb = rx_byte == OP_WHITE_BLACK;
   wire is_bb = rx_byte == OP_BLACK_BLACK;
   wire is_table = is_ww | is_bw | is_wb | is_bb;
   wire is_temp = rx_byte == OP_TEMP_READ;
   wire is_status = rx_byte == OP_STATUS_READ;
   wire is_read = is_temp | is_status;
   wire takes_param = is_panel | is_pwr | is_pfs | is_table |
      (rx_byte == OP_PLL) | (rx_byte == OP_BORDER_INTERVAL) | (rx_byte == OP_TIMING_CONTROL_SETTING) |
      (rx_byte == OP_VCOM_VALUE) | (rx_byte == OP_VCOM_DC);
   // Only read with a table opcode, so the last arm doubles as default
   wire [1:0] nxt_table_sel = is_ww ? TBL_WW : is_bw ? TBL_BW : is_wb ? TBL_WB : TBL_BB;

   // Parameter byte while a parameter run is open
   // Bytes outside a run fall through, so stray data cannot land
   wire wr_param = got_param && (state_ff == ST_PARAM);
   wire wr_first = wr_param && (pidx_ff == 3'd0);
   wire op_table = (opcode_ff == OP_WHITE_WHITE) || (opcode_ff == OP_BLACK_WHITE) ||
      (opcode_ff == OP_WHITE_BLACK) || (opcode_ff == OP_BLACK_BLACK);
   wire soft_reset = wr_first && (opcode_ff == OP_PANEL_CONFIG) &&
      !rx_byte[PANEL_SOFT_RESET_BIT];

   // Read data
   wire [7:0] status_byte = {2'b00, i2c_err, i2c_busy_n, data_flag, pon_ff, pof_ff, busy_n};
   wire rd_next = got_param && (state_ff == ST_READ);
   wire [1:0] rd_count = (opcode_ff == OP_TEMP_READ) ? NREAD_TEMP : NREAD_STATUS;
   wire [7:0] rd_second = (opcode_ff == OP_TEMP_READ) ?
      {temp_value[2:0], 5'b00000} : 8'h00;
   wire [7:0] rd_first = is_temp ? temp_value[10:3] : status_byte;

   // Host holds off while busy; status and pin share one source
   assign busy_n = ~engine_busy;
   assign sda_out = tx_ff[7];
   // Released in the select slot so the host can drive its D/C bit
   assign sda_oe = (state_ff == ST_READ) && !spi_cs_n && !dc_slot;

   // Command state
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         ST_IDLE,
         ST_PARAM,
         ST_READ: begin
            if (got_cmd) begin
               // A fresh opcode always ends the open run
               if (is_read) begin
                  nxt_state = ST_READ;
               end else if (takes_param) begin
                  nxt_state = ST_PARAM;
               end else begin
                  nxt_state = ST_IDLE;
               end
            end else if (wr_param && !op_table && (opcode_ff != OP_POWER_LEVELS)) begin
               nxt_state = ST_IDLE;
            end else if (wr_param && (opcode_ff == OP_POWER_LEVELS) &&
                  (pidx_ff == NPARAM_POWER_LEVELS - 3'd1)) begin
               nxt_state = ST_IDLE;
            end else if (rd_next && (ridx_ff == rd_count - 2'd1)) begin
               nxt_state = ST_IDLE;
            end
         end
         default: begin
            nxt_state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         state_ff <= ST_IDLE;
         sclk_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         sclk_ff <= spi_sclk;
      end
   end

   // Bit counter restarts whenever chip select drops out mid-frame
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         bit_cnt_ff <= 4'd0;
         dc_bit_ff <= 1'b0;
         rx_ff <= 8'h00;
      end else if (spi_cs_n) begin
         bit_cnt_ff <= 4'd0;
      end else if (sclk_rise) begin
         bit_cnt_ff <= last_bit ? 4'd0 : bit_cnt_ff + 4'd1;
         // The D/C bit of a 9-bit frame stays out of the data shifter
         if (dc_slot) begin
            dc_bit_ff <= sda_in;
         end else begin
            rx_ff <= rx_byte;
         end
      end
   end

   // Read shifter: host samples on the rising edge, next bit follows it
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         tx_ff <= 8'h00;
         ridx_ff <= 2'd0;
      // Loaded on every opcode; only the read state lets it reach the pin
      end else if (got_cmd) begin
         tx_ff <= rd_first;
         ridx_ff <= 2'd0;
      end else if (rd_next) begin
         tx_ff <= (ridx_ff == 2'd0) ? rd_second : 8'h00;
         ridx_ff <= ridx_ff + 2'd1;
      end else if (sclk_rise && !dc_slot && (state_ff == ST_READ)) begin
         tx_ff <= {tx_ff[6:0], 1'b0};
      end
   end

   // Opcode and parameter index
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         opcode_ff <= 8'h00;
         pidx_ff <= 3'd0;
      end else if (got_cmd) begin
         opcode_ff <= rx_byte;
         pidx_ff <= 3'd0;
      // Index saturates so an overlong run never wraps back to byte zero
      end else if (wr_param && pidx_ff != 3'd7) begin
         pidx_ff <= pidx_ff + 3'd1;
      end
   end

   // Power state flags; reset sets the power-off flag and clears the power-on flag
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         pon_ff <= RST_STATUS[STAT_PON_BIT];
         pof_ff <= RST_STATUS[STAT_POF_BIT];
      end else if (got_cmd && is_pup) begin
         pon_ff <= 1'b1;
         pof_ff <= 1'b0;
      end else if ((got_cmd && is_pdown) || soft_reset) begin
         pon_ff <= 1'b0;
         pof_ff <= 1'b1;
      end
   end

   // Parameter store; a soft reset byte restores every default
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         panel_setting <= RST_PANEL_SETTING;
         pwr_enables <= RST_PWR_ENABLES;
         pwr_levels <= RST_PWR_LEVELS;
         source_high_level <= RST_SRC_HIGH;
         source_low_level <= RST_SRC_LOW;
         red_source_level <= RST_RED_SRC;
         power_off_sequence <= RST_POWER_OFF_SEQ;
         pll_control <= RST_PLL;
         vcom_data_interval <= RST_VCOM_DATA_INTERVAL;
         timing_control_setting <= RST_TIMING_CONTROL_SETTING;
         vcom_value <= RST_VCOM_VALUE;
         vcom_dc_setting <= RST_VCOM_DC;
      // The soft reset byte itself is not kept in the panel register
      end else if (soft_reset) begin
         panel_setting <= RST_PANEL_SETTING;
         pwr_enables <= RST_PWR_ENABLES;
         pwr_levels <= RST_PWR_LEVELS;
         source_high_level <= RST_SRC_HIGH;
         source_low_level <= RST_SRC_LOW;
         red_source_level <= RST_RED_SRC;
         power_off_sequence <= RST_POWER_OFF_SEQ;
         pll_control <= RST_PLL;
         vcom_data_interval <= RST_VCOM_DATA_INTERVAL;
         timing_control_setting <= RST_TIMING_CONTROL_SETTING;
         vcom_value <= RST_VCOM_VALUE;
         vcom_dc_setting <= RST_VCOM_DC;
      end else if (wr_param) begin
         case (opcode_ff)
            OP_PANEL_CONFIG: begin
               if (pidx_ff == 3'd0) begin
                  panel_setting <= rx_byte;
               end
            end
            OP_POWER_LEVELS: begin
               case (pidx_ff)
                  3'd0: pwr_enables <= rx_byte & MSK_PWR_ENABLES;
                  3'd1: pwr_levels <= rx_byte & MSK_PWR_LEVELS;
                  3'd2: source_high_level <= rx_byte & MSK_LEVEL6;
                  3'd3: source_low_level <= rx_byte & MSK_LEVEL6;
                  3'd4: red_source_level <= rx_byte & MSK_LEVEL6;
                  default: begin
                  end
               endcase
            end
            OP_POWER_DOWN_TIMING: begin
               if (pidx_ff == 3'd0) begin
                  power_off_sequence <= rx_byte & MSK_POWER_OFF_SEQ;
               end
            end
            OP_PLL: begin
               if (pidx_ff == 3'd0) begin
                  pll_control <= rx_byte & MSK_PLL;
               end
            end
            OP_BORDER_INTERVAL: begin
               if (pidx_ff == 3'd0) begin
                  vcom_data_interval <= rx_byte;
               end
            end
            OP_TIMING_CONTROL_SETTING: begin
               if (pidx_ff == 3'd0) begin
                  timing_control_setting <= rx_byte;
               end
            end
            OP_VCOM_VALUE: begin
               if (pidx_ff == 3'd0) begin
                  vcom_value <= rx_byte & MSK_VCOM7;
               end
            end
            OP_VCOM_DC: begin
               if (pidx_ff == 3'd0) begin
                  vcom_dc_setting <= rx_byte & MSK_VCOM7;
               end
            end
            default: begin
            end
         endcase
      end
   end

   // Command events and table byte stream
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         power_down_pulse <= 1'b0;
         power_up_pulse <= 1'b0;
         table_start_pulse <= 1'b0;
         table_select <= TBL_WW;
         table_data_valid <= 1'b0;
         table_data <= 8'h00;
      end else begin
         power_down_pulse <= got_cmd && is_pdown;
         power_up_pulse <= got_cmd && is_pup;
         table_start_pulse <= got_cmd && is_table;
         if (got_cmd && is_table) begin
            table_select <= nxt_table_sel;
         end
         // Table length is open-ended; the next opcode closes it
         table_data_valid <= wr_param && op_table;
         if (wr_param && op_table) begin
            table_data <= rx_byte;
         end
      end
   end
endmodule : epd_cmd_decoder

// >>> hdl/epd_cmd_pkg.sv
// Opcodes, parameter defaults, masks and field positions of the command decoder
package epd_cmd_pkg;
   // Opcodes
   localparam logic [7:0] OP_PANEL_CONFIG = 8'h00;
   localparam logic [7:0] OP_POWER_LEVELS = 8'h01;
   localparam logic [7:0] OP_POWER_DOWN = 8'h02;
   localparam logic [7:0] OP_POWER_DOWN_TIMING = 8'h03;
   localparam logic [7:0] OP_POWER_UP = 8'h04;
   localparam logic [7:0] OP_WHITE_WHITE = 8'h21;
   localparam logic [7:0] OP_BLACK_WHITE = 8'h22;
   localparam logic [7:0] OP_WHITE_BLACK = 8'h23;
   localparam logic [7:0] OP_BLACK_BLACK = 8'h24;
   localparam logic [7:0] OP_PLL = 8'h30;
   localparam logic [7:0] OP_TEMP_READ = 8'h40;
   localparam logic [7:0] OP_BORDER_INTERVAL = 8'h50;
   localparam logic [7:0] OP_TIMING_CONTROL_SETTING = 8'h60;
   localparam logic [7:0] OP_STATUS_READ = 8'h71;
   localparam logic [7:0] OP_VCOM_VALUE = 8'h81;
   localparam logic [7:0] OP_VCOM_DC = 8'h82;

   // Parameter defaults
   localparam logic [7:0] RST_PANEL_SETTING = 8'h07;
   localparam logic [7:0] RST_PWR_ENABLES = 8'h03;
   localparam logic [7:0] RST_PWR_LEVELS = 8'h00;
   localparam logic [7:0] RST_SRC_HIGH = 8'h26;
   localparam logic [7:0] RST_SRC_LOW = 8'h26;
   localparam logic [7:0] RST_RED_SRC = 8'h03;
   localparam logic [7:0] RST_POWER_OFF_SEQ = 8'h00;
   localparam logic [7:0] RST_PLL = 8'h3c;
   localparam logic [7:0] RST_VCOM_DATA_INTERVAL = 8'hd7;
   localparam logic [7:0] RST_TIMING_CONTROL_SETTING = 8'h22;
   localparam logic [7:0] RST_VCOM_VALUE = 8'h00;
   localparam logic [7:0] RST_VCOM_DC = 8'h00;
   localparam logic [7:0] RST_STATUS = 8'h02;

   // Valid-bit masks, don't-care positions read as zero
   localparam logic [7:0] MSK_PWR_ENABLES = 8'h03;
   localparam logic [7:0] MSK_PWR_LEVELS = 8'h07;
   localparam logic [7:0] MSK_LEVEL6 = 8'h3f;
   localparam logic [7:0] MSK_POWER_OFF_SEQ = 8'h3f;
   localparam logic [7:0] MSK_PLL = 8'h7f;
   localparam logic [7:0] MSK_VCOM7 = 8'h7f;

   // Parameter counts
   localparam logic [2:0] NPARAM_POWER_LEVELS = 3'd5;
   localparam logic [1:0] NREAD_TEMP = 2'd2;
   localparam logic [1:0] NREAD_STATUS = 2'd1;

   // Field positions
   localparam int PANEL_SOFT_RESET_BIT = 0;
   localparam int STAT_BUSY_N_BIT = 0;
   localparam int STAT_POF_BIT = 1;
   localparam int STAT_PON_BIT = 2;
   localparam int STAT_DATA_FLAG_BIT = 3;
   localparam int STAT_I2C_BUSY_N_BIT = 4;
   localparam int STAT_I2C_ERR_BIT = 5;

   // Serial framing
   localparam logic [3:0] FRAME_4WIRE = 4'd8;
   localparam logic [3:0] FRAME_3WIRE = 4'd9;

   // Transition table selects
   localparam logic [1:0] TBL_WW = 2'd0;
   localparam logic [1:0] TBL_BW = 2'd1;
   localparam logic [1:0] TBL_WB = 2'd2;
   localparam logic [1:0] TBL_BB = 2'd3;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_PARAM = 3'b010,
      ST_READ = 3'b100
   } epd_state_e;
endpackage : epd_cmd_pkg

// >>> tb/epd_cmd_decoder_assertions.sv
// Port-level concurrent checks of the command decoder
module epd_cmd_chk (
   // Clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // Serial port
   input wire logic spi_cs_n,
   input wire logic spi_sclk,
   input wire logic cmd_param_select,
   input wire logic serial_mode_select,
   input wire logic sda_oe,
   // Status, parameters and events
   input wire logic engine_busy,
   input wire logic busy_n,
   input wire logic [7:0] panel_setting,
   input wire logic [7:0] pwr_levels,
   input wire logic [7:0] source_high_level,
   input wire logic [7:0] vcom_value,
   input wire logic [7:0] vcom_data_interval,
   input wire logic power_down_pulse,
   input wire logic power_up_pulse,
   input wire logic table_start_pulse,
   input wire logic table_data_valid
);
   import epd_cmd_pkg::*;
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!resetn);
   // Outputs settle one cycle after the byte-ending edge, so look one sample back
   sequence done_s;
      $past(spi_sclk, 1) && !$past(spi_sclk, 2) && !$past(spi_cs_n, 1);
   endsequence
   sequence cmd_s;
      done_s ##0 !$past(cmd_param_select, 1);
   endsequence
   sequence param_s;
      done_s ##0 $past(cmd_param_select, 1);
   endsequence
   chk_busy_mirror: assert property (busy_n == !engine_busy)
      else $error("busy_n does not mirror engine_busy");
   chk_up_single: assert property (power_up_pulse |=> !power_up_pulse)
      else $error("power up pulse longer than one cycle");
   chk_up_cause: assert property (power_up_pulse && !serial_mode_select |-> cmd_s)
      else $error("power up pulse without a command byte");
   chk_down_cause: assert property (power_down_pulse && !serial_mode_select |-> cmd_s)
      else $error("power down pulse without a command byte");
   chk_table_cause: assert property (table_start_pulse && !serial_mode_select |-> cmd_s)
      else $error("table start without a command byte");
   chk_data_param: assert property (table_data_valid && !serial_mode_select |-> param_s)
      else $error("table data without a parameter byte");
   chk_param_cause: assert property ($changed(vcom_data_interval) |-> done_s)
      else $error("interval register changed without a byte");
   chk_oe_select: assert property (sda_oe |-> !spi_cs_n)
      else $error("sda driven while not selected");
   chk_reset_load: assert property ($rose(resetn) |-> panel_setting == RST_PANEL_SETTING
      && vcom_data_interval == RST_VCOM_DATA_INTERVAL)
      else $error("defaults not loaded at reset");
   chk_dontcare_zero: assert property (source_high_level[7:6] == 2'h0
      && pwr_levels[7:3] == 5'h00 && vcom_value[7] == 1'b0)
      else $error("don't-care bits stored");
endmodule : epd_cmd_chk

bind epd_cmd_decoder epd_cmd_chk chk (
   .core_clk, .resetn, .spi_cs_n, .spi_sclk, .cmd_param_select, .serial_mode_select,
   .sda_oe, .engine_busy, .busy_n, .panel_setting, .pwr_levels, .source_high_level,
   .vcom_value, .vcom_data_interval, .power_down_pulse, .power_up_pulse,
   .table_start_pulse, .table_data_valid
);

// >>> tb/epd_host_model.sv
// Host model driving the serial command port
module epd_host_model (
   // Clock, mode select and device outputs
   input wire logic core_clk,
   input wire logic busy_n,
   input wire logic serial_mode_select,
   input wire logic sda_out,
   input wire logic sda_oe,
   // Serial port
   output logic spi_cs_n,
   output logic spi_sclk,
   output logic cmd_param_select,
   output logic sda_in
);
   timeunit 1ns;
   timeprecision 1ps;
   logic sda_drv = 1'b0;
   initial begin
      spi_cs_n = 1'b1;
      spi_sclk = 1'b0;
      cmd_param_select = 1'b1;
   end
   // Shared data line: device wins while it drives
   assign sda_in = sda_oe ? sda_out : sda_drv;
   task automatic clk_bit(input logic b);
      sda_drv = b;
      repeat (2) @(negedge core_clk);
      spi_sclk = 1'b1;
      repeat (2) @(negedge core_clk);
      spi_sclk = 1'b0;
   endtask : clk_bit
   task automatic send(input logic dc, input logic [7:0] b, input int slow);
      int w;
      w = 0;
      while (busy_n !== 1'b1 && w < 2000) begin
         @(negedge core_clk);
         w++;
      end
      spi_cs_n = 1'b0;
      cmd_param_select = dc;
      if (serial_mode_select) clk_bit(dc);
      for (int i = 7; i >= 0; i--) clk_bit(b[i]);
      // Idle line shows the inverse so a late sample is caught
      sda_drv = ~b[0];
      repeat (slow) @(negedge core_clk);
      spi_cs_n = 1'b1;
      cmd_param_select = ~dc;
      @(negedge core_clk);
   endtask : send
   task automatic recv(output logic [7:0] b);
      spi_cs_n = 1'b0;
      for (int i = 7; i >= 0; i--) begin
         repeat (2) @(negedge core_clk);
         b[i] = sda_in;
         spi_sclk = 1'b1;
         repeat (2) @(negedge core_clk);
         spi_sclk = 1'b0;
      end
      spi_cs_n = 1'b1;
      @(negedge core_clk);
   endtask : recv
endmodule : epd_host_model

// >>> tb/epaper_command_decoder_test.sv
// Self-checking bench of the command decoder
module epaper_command_decoder_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk = 1'b0;
   logic resetn = 1'b0;
   logic serial_mode_select = 1'b0;
   logic engine_busy = 1'b0;
   logic i2c_err = 1'b0;
   logic i2c_busy_n = 1'b1;
   logic data_flag = 1'b0;
   logic [10:0] temp_value = 11'h000;
   logic spi_cs_n, spi_sclk, cmd_param_select, sda_in, sda_out, sda_oe, busy_n;
   logic pdn, pup, tsp, tdv;
   logic [1:0] tsel;
   logic [7:0] tdat, v;
   logic [7:0] r [12];
   // Defaults and kept-bit masks in output order
   int m0 [12] = '{8'h07, 8'h03, 8'h00, 8'h26, 8'h26, 8'h03,
      8'h00, 8'h3c, 8'hd7, 8'h22, 8'h00, 8'h00};
   int m [12];
   int msk [12] = '{8'hff, 8'h03, 8'h07, 8'h3f, 8'h3f, 8'h3f,
      8'h3f, 8'h7f, 8'hff, 8'hff, 8'h7f, 8'h7f};
   logic [7:0] ops [8] = '{8'h00, 8'h01, 8'h03, 8'h30, 8'h50, 8'h60, 8'h81, 8'h82};
   int bas [8] = '{0, 1, 6, 7, 8, 9, 10, 11};
   logic [7:0] tq [$];
   logic [7:0] tseen [$];
   logic power_up_cmd = 1'b0;
   logic power_down_cmd = 1'b1;
   int seed = 32'h27f676bb;
   int error_cnt = 0;
   int samples_checked = 0;
   int n_up = 0;
   int n_dn = 0;
   int n_ts = 0;
   int n;
   always #20 core_clk = ~core_clk;
   epd_cmd_decoder uut (
      .core_clk(core_clk), .resetn(resetn), .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk),
      .cmd_param_select(cmd_param_select), .serial_mode_select(serial_mode_select),
      .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .engine_busy(engine_busy),
      .i2c_err(i2c_err), .i2c_busy_n(i2c_busy_n), .data_flag(data_flag),
      .temp_value(temp_value), .busy_n(busy_n), .panel_setting(r[0]), .pwr_enables(r[1]),
      .pwr_levels(r[2]), .source_high_level(r[3]), .source_low_level(r[4]),
      .red_source_level(r[5]), .power_off_sequence(r[6]), .pll_control(r[7]),
      .vcom_data_interval(r[8]), .timing_control_setting(r[9]), .vcom_value(r[10]),
      .vcom_dc_setting(r[11]), .power_down_pulse(pdn), .power_up_pulse(pup),
      .table_start_pulse(tsp), .table_select(tsel), .table_data_valid(tdv), .table_data(tdat));
   epd_host_model host (
      .core_clk(core_clk), .busy_n(busy_n), .serial_mode_select(serial_mode_select),
      .sda_out(sda_out), .sda_oe(sda_oe), .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk),
      .cmd_param_select(cmd_param_select), .sda_in(sda_in));
   always @(posedge core_clk) begin
      if (pup === 1'b1) n_up++;
      if (pdn === 1'b1) n_dn++;
      if (tsp === 1'b1) n_ts++;
      if (tdv === 1'b1) tseen.push_back(tdat);
   end
   task automatic cmp8(input string nm, input logic [7:0] e, input logic [7:0] a);
      samples_checked++;
      if (a !== e) begin
         error_cnt++;
         $display("unexpected %s expected %h seen %h", nm, e, a);
      end
   endtask : cmp8
   task automatic chk_regs();
      for (int i = 0; i < 12; i++) cmp8("param", 8'(m[i]), r[i]);
   endtask : chk_regs
   // Negative base marks a table load: bytes go to the data stream
   task automatic wr(input logic [7:0] op, input int base, input int cnt);
      logic [7:0] b;
      host.send(1'b0, op, 0);
      for (int k = 0; k < cnt; k++) begin
         b = 8'($random(seed));
         if (base == 0) b[0] = 1'b1;
         host.send(1'b1, b, k);
         if (base >= 0) m[base + k] = b & 8'(msk[base + k]);
         else tq.push_back(b);
      end
      repeat (2) @(negedge core_clk);
      chk_regs();
   endtask : wr
   task automatic rd_status();
      logic [7:0] s;
      {i2c_err, i2c_busy_n, data_flag} = 3'($random(seed));
      host.send(1'b0, 8'h71, 0);
      host.recv(s);
      cmp8("status", {2'b00, i2c_err, i2c_busy_n, data_flag, power_up_cmd, power_down_cmd, ~engine_busy}, s);
   endtask : rd_status
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : print_verdict
   initial begin
      repeat (30000) @(posedge core_clk);
      error_cnt++;
      print_verdict();
   end
   initial begin
      m = m0;
      repeat (16) @(negedge core_clk);
      resetn = 1'b1;
      @(negedge core_clk);
      chk_regs();
      host.send(1'b1, 8'h5a, 0);
      chk_regs();
      rd_status();
      $display("test reset done");
      for (int i = 0; i < 8; i++) wr(ops[i], bas[i], ops[i] == 8'h01 ? 5 : 1);
      wr(8'h01, 1, 2);
      wr(8'h50, 8, 1);
      $display("test params done");
      n = n_up;
      wr(8'h04, -1, 0);
      cmp8("up_pulses", 8'(n + 1), 8'(n_up));
      power_up_cmd = 1'b1;
      power_down_cmd = 1'b0;
      rd_status();
      n = n_dn;
      wr(8'h02, -1, 0);
      cmp8("down_pulses", 8'(n + 1), 8'(n_dn));
      power_up_cmd = 1'b0;
      power_down_cmd = 1'b1;
      rd_status();
      $display("test power done");
      for (int t = 0; t < 4; t++) begin
         tq.delete();
         tseen.delete();
         n = n_ts;
         wr(8'(8'h21 + t), -1, 3);
         cmp8("tbl_starts", 8'(n + 1), 8'(n_ts));
         cmp8("tbl_sel", 8'(t), {6'h00, tsel});
         cmp8("tbl_bytes", 8'(tq.size()), 8'(tseen.size()));
         foreach (tq[k]) cmp8("tbl_data", tq[k], tseen[k]);
      end
      $display("test tables done");
      host.send(1'b0, 8'h04, 0);
      host.send(1'b0, 8'h00, 0);
      host.send(1'b1, 8'h06, 0);
      m = m0;
      power_up_cmd = 1'b0;
      power_down_cmd = 1'b1;
      chk_regs();
      rd_status();
      $display("test soft reset done");
      temp_value = 11'($random(seed));
      host.send(1'b0, 8'h40, 2);
      host.recv(v);
      cmp8("temp_hi", temp_value[10:3], v);
      host.recv(v);
      cmp8("temp_lo", {temp_value[2:0], 5'h00}, v);
      $display("test temperature done");
      serial_mode_select = 1'b1;
      wr(8'h50, 8, 1);
      wr(8'h00, 0, 1);
      serial_mode_select = 1'b0;
      $display("test three wire done");
      resetn = 1'b0;
      @(negedge core_clk);
      resetn = 1'b1;
      m = m0;
      @(negedge core_clk);
      chk_regs();
      rd_status();
      $display("test mid reset done");
      engine_busy = 1'b1;
      @(negedge core_clk);
      cmp8("busy_n", 8'h00, {7'h00, busy_n});
      fork
         begin
            repeat (30) @(negedge core_clk);
            engine_busy = 1'b0;
         end
      join_none
      wr(8'h60, 9, 1);
      cmp8("busy_n", 8'h01, {7'h00, busy_n});
      $display("test busy done");
      print_verdict();
   end
endmodule : epaper_command_decoder_test
